// >>> tb/test_txq_path.sv
// Self-checking bench for the transmit queue path.
// Assumes the host model answers every request of the path.
`timescale 1ns/10ps
module test_txq_path
    import txq_pkg::*;
;
    typedef struct packed {
        logic        w;
        logic [11:0] a;
        logic [31:0] x;
        logic        e;
    } txq_row_type;
    // Scheme codes are written only while the arbiter is halted.
    localparam txq_row_type ROWS [14] = '{
        '{1'h0, 12'h000, 32'h0, 1'h0}, '{1'h0, 12'h004, 32'h0, 1'h0},
        '{1'h0, 12'h020, 32'hA0, 1'h0}, '{1'h0, 12'h024, 32'h0, 1'h0},
        '{1'h0, 12'h014, 32'h1, 1'h0}, '{1'h0, 12'h018, 32'h0, 1'h1},
        '{1'h1, 12'h000, 32'h1, 1'h0}, '{1'h1, 12'h004, 32'h1, 1'h0},
        '{1'h1, 12'h004, 32'h4, 1'h0}, '{1'h1, 12'h004, 32'h5, 1'h0},
        '{1'h1, 12'h004, 32'h6, 1'h0}, '{1'h1, 12'h004, 32'h2, 1'h0},
        '{1'h1, 12'h024, 32'h14, 1'h0}, '{1'h1, 12'h000, 32'h0, 1'h0}};

    logic        i_ref_clk, i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rdat;
    logic        o_fetch_req, i_fetch_done, o_data_req, i_data_byte_valid, i_data_last;
    logic        o_wb_req, i_wb_done, o_mac_start, i_mac_done, er;
    logic [6:0]  o_fetch_queue, o_data_queue, o_wb_queue;
    logic [2:0]  o_data_pb, o_mac_pb;
    logic [7:0]  mac_mask = 8'h00;
    logic        sf_bad = 1'h0;
    int          n_fail = 0, checks_done = 0, n_freq = 0, n_last = 0, n_mac = 0, n_wb = 0, f0;

    txq_path txq_path_i (.i_ref_clk, .i_rst, .i_psel,
        .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
        .o_fetch_req, .o_fetch_queue, .i_fetch_done, .o_data_req, .o_data_queue, .o_data_pb,
        .i_data_byte_valid, .i_data_last, .o_wb_req, .o_wb_queue, .i_wb_done, .o_mac_start,
        .o_mac_pb, .i_mac_done);
    txq_host_model txq_host_model_i (.i_ref_clk, .i_rst,
        .i_fetch_req(o_fetch_req), .i_data_req(o_data_req), .i_wb_req(o_wb_req),
        .i_mac_start(o_mac_start), .o_fetch_done(i_fetch_done), .o_byte_valid(i_data_byte_valid),
        .o_data_last(i_data_last), .o_wb_done(i_wb_done), .o_mac_done(i_mac_done));

    initial begin
        i_ref_clk = 1'h0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    // Sends are judged against earlier packet ends.
    always @(posedge i_ref_clk) begin
        if (o_mac_start === 1'h1) begin
            if (n_last <= n_mac) sf_bad = 1'h1;
            n_mac++;
            mac_mask[o_mac_pb] = 1'h1;
        end
        if (i_data_last === 1'h1) n_last++;
        if (o_fetch_req === 1'h1) n_freq++;
        if (o_wb_req === 1'h1) n_wb++;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: %s got %h want %h", $time, msg, seen, exp);
        end
    endtask : chk

    // Holds the request until pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        i_psel <= 1'h1;
        i_penable <= 1'h0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_ref_clk);
        i_penable <= 1'h1;
        do @(posedge i_ref_clk); while (o_pready !== 1'h1);
        rdat = o_prdata;
        er = o_pslverr;
        i_psel <= 1'h0;
        i_penable <= 1'h0;
        @(posedge i_ref_clk);
    endtask : apb

    task automatic wait_mac(input int target);
        for (int t = 0; n_mac < target && t < 600; t++) @(posedge i_ref_clk);
        chk(32'(n_mac), 32'(target), "packets sent");
    endtask : wait_mac

    initial begin
        repeat (5000) @(posedge i_ref_clk);
        n_fail++;
        test_done;
    end

    initial begin
        {i_rst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = {1'h1, 47'h0};
        repeat (5) @(posedge i_ref_clk);
        i_rst <= 1'h0;
        @(posedge i_ref_clk);
        foreach (ROWS[k]) begin
            if (ROWS[k].w) apb(1'h1, ROWS[k].a, ROWS[k].x);
            apb(1'h0, ROWS[k].a, 32'h0);
            chk(rdat, ROWS[k].x, "row");
            chk({31'h0, er}, {31'h0, ROWS[k].e}, "pslverr");
        end
        $display("register test done");
        // Queue 0x20 feeds buffer 1, queue 0x00 buffer 0 in eight-class mode.
        f0 = n_freq;
        apb(1'h1, TXQ_ADDR_CTRL, 32'h1);
        apb(1'h1, TXQ_ADDR_QSEL, 32'h120);
        apb(1'h1, TXQ_ADDR_QTAIL, 32'h1);
        apb(1'h1, TXQ_ADDR_QSEL, 32'h100);
        apb(1'h1, TXQ_ADDR_QTAIL, 32'h1);
        repeat (40) @(posedge i_ref_clk);
        chk(32'(n_freq - f0), 32'h0, "fetch while halted");
        apb(1'h1, TXQ_ADDR_CTRL, 32'h2);
        wait_mac(2);
        chk({24'h0, mac_mask}, 32'h3, "buffers used");
        chk({31'h0, sf_bad}, 32'h0, "early send");
        chk(32'(n_wb > 0), 32'h1, "status write-back");
        apb(1'h0, TXQ_ADDR_QSTAT, 32'h0);
        chk(rdat, 32'h0, "queue drained");
        $display("traffic test done");
        f0 = n_freq;
        apb(1'h1, TXQ_ADDR_QSEL, 32'h140);
        apb(1'h1, TXQ_ADDR_QTAIL, 32'h1);
        apb(1'h1, TXQ_ADDR_QSEL, 32'h001);
        apb(1'h1, TXQ_ADDR_QTAIL, 32'h1);
        repeat (60) @(posedge i_ref_clk);
        chk(32'(n_freq - f0), 32'h0, "skipped queue");
        apb(1'h0, TXQ_ADDR_QSTAT, 32'h0);
        chk(rdat, 32'h100, "pending kept");
        apb(1'h1, TXQ_ADDR_QSEL, 32'h101);
        wait_mac(3);
        apb(1'h1, TXQ_ADDR_PBSIZE0 + 12'h008, 32'h14);
        wait_mac(4);
        chk({24'h0, mac_mask}, 32'h7, "buffer two used");
        $display("skip test done");
        test_done;
    end
endmodule : test_txq_path

// >>> tb/txq_host_model.sv
// Stand-in for host memory and the MAC: answers each held request with one pulse; a data request also gets 14 byte pulses.
// Assumes requests are held until answered.
`timescale 1ns/10ps
module txq_host_model #(
    parameter int DLY    = 3,
    parameter int NBYTES = 14
) (
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    // Requests
    input  wire logic i_fetch_req,
    input  wire logic i_data_req,
    input  wire logic i_wb_req,
    input  wire logic i_mac_start,
    // Answers
    output logic      o_fetch_done,
    output logic      o_byte_valid,
    output logic      o_data_last,
    output logic      o_wb_done,
    output logic      o_mac_done
);
    int fc, dc, wc, mc;

    // A request still held after its pulse is served again.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            {fc, dc, wc, mc} <= '0;
            {o_fetch_done, o_byte_valid, o_data_last, o_wb_done, o_mac_done} <= '0;
        end else begin
            fc <= (i_fetch_req && !o_fetch_done) ? fc + 1 : 0;
            o_fetch_done <= i_fetch_req && !o_fetch_done && fc == DLY;
            dc <= (i_data_req && !o_data_last) ? dc + 1 : 0;
            o_byte_valid <= i_data_req && !o_data_last && dc >= DLY && dc < DLY + NBYTES;
            o_data_last <= i_data_req && !o_data_last && dc == DLY + NBYTES - 1;
            wc <= (i_wb_req && !o_wb_done) ? wc + 1 : 0;
            o_wb_done <= i_wb_req && !o_wb_done && wc == DLY;
            mc <= i_mac_start ? 1 : (mc != 0 && mc < DLY + NBYTES) ? mc + 1 : 0;
            o_mac_done <= mc == DLY + NBYTES;
        end
    end
endmodule : txq_host_model

// >>> tb/txq_path_checker.sv
// Concurrent checks on the transmit queue path's top ports.
// Assumes the register offsets and scheme codes of txq_pkg.
`timescale 1ns/10ps
module txq_path_checker
    import txq_pkg::*;
(
    // Clock and reset
    input wire logic       i_ref_clk,
    input wire logic       i_rst,
    // APB
    input wire logic       i_psel,
    input wire logic       i_penable,
    input wire logic       i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic       o_pready,
    // Host and MAC side
    input wire logic       o_fetch_req,
    input wire logic       i_fetch_done,
    input wire logic       o_data_req,
    input wire logic [6:0] o_data_queue,
    input wire logic [2:0] o_data_pb,
    input wire logic       i_data_last,
    input wire logic       o_wb_req,
    input wire logic       o_mac_start,
    input wire logic [2:0] o_mac_pb
);
    logic [2:0] scheme_reg;
    logic       arbdis_reg;
    logic       wben_reg;
    wire logic  wr_done;
    assign wr_done = i_psel && i_penable && o_pready && i_pwrite;

    // Shadow control fields, written at the access edge.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            scheme_reg <= TXQ_SCHEME_RESET;
            arbdis_reg <= 1'h0;
            wben_reg   <= 1'h0;
        end else if (wr_done) begin
            if (i_paddr == TXQ_ADDR_CTRL) arbdis_reg <= i_pwdata[TXQ_CTRL_ARBDIS_BIT];
            if (i_paddr == TXQ_ADDR_CTRL) wben_reg <= i_pwdata[TXQ_CTRL_WBEN_BIT];
            if (i_paddr == TXQ_ADDR_SCHEME) scheme_reg <= i_pwdata[2:0];
        end
    end

    function automatic logic [2:0] pb_of(input logic [2:0] s, input logic [6:0] q);
        if (s[2])
            return (s[1:0] == TXQ_TCM_EIGHT) ? q[2:0] :
                   (s[1:0] == TXQ_TCM_FOUR) ? {1'h0, q[1:0]} : 3'h0;
        if (s[1:0] == TXQ_TCM_EIGHT)
            return !q[6] ? {2'h0, q[5]} : !q[5] ? {2'h1, q[4]} : {1'h1, q[4:3]};
        return (s[1:0] == TXQ_TCM_FOUR) ? {1'h0, q[6:5]} : 3'h0;
    endfunction : pb_of

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_fetch_end;
        o_fetch_req && i_fetch_done;
    endsequence
    // A grant made at the halting edge may still show.
    sequence s_halted;
        arbdis_reg && $past(arbdis_reg, 2);
    endsequence

    a_apb_ready: assert property (s_setup |=> o_pready)
        else $error("no APB answer");
    a_fetch_held: assert property (o_fetch_req && !i_fetch_done |=> o_fetch_req)
        else $error("fetch dropped early");
    a_fetch_release: assert property (s_fetch_end |=> !o_fetch_req)
        else $error("fetch held too long");
    a_halt_fetch: assert property (s_halted ##0 !o_fetch_req |=> !o_fetch_req)
        else $error("fetch while halted");
    a_halt_mac: assert property (s_halted |-> !o_mac_start)
        else $error("send while halted");
    a_buf_map: assert property (o_data_req |-> o_data_pb == pb_of(scheme_reg, o_data_queue))
        else $error("wrong packet buffer");
    a_store_fwd: assert property (o_mac_start && o_data_req |-> o_data_pb != o_mac_pb)
        else $error("send from filling buffer");
    a_wb_after: assert property (wben_reg && o_data_req && i_data_last |-> ##[1:4] o_wb_req)
        else $error("no status write-back");
endmodule : txq_path_checker

bind txq_path txq_path_checker txq_path_checker_i (.i_ref_clk, .i_rst, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_fetch_req, .i_fetch_done, .o_data_req,
    .o_data_queue, .o_data_pb, .i_data_last, .o_wb_req, .o_mac_start, .o_mac_pb);

// >>> verilog/txq_path.sv
// Transmit descriptor queue path: per-queue pending and on-die descriptor counts,
// round-robin fetch arbiter, store-and-forward packet buffers, output arbiter.
// Assumes a host memory agent on the fetch and data request ports.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/10ps

// Functional notes
// (R1) Software advances tail to publish descriptors.
// (R2) Send packet only after fully buffered.
// (R3) Packet descriptors are consecutive in ring.
// (R4) Buffers may start at any byte.
// (R5) Packet holds at least fourteen header bytes.
// (R6) Buffers per packet bounded by threshold.
// (R7) 128 on-die queues, one ring each.
// (R8) Each on-die queue holds 40 descriptors.
// (R9) Fetch arbiter orders descriptor loads.
// (R10) Optional status write-back after buffering.
// (R11) Up to eight packet buffers, mode sized.
// (R12) Arbitrate buffers toward MAC when several.
// (R13) Each queue maps to one buffer.
// (R14) Virtualization pools are equal sized.
// (R15) Pool queues may map to different buffers.
// (R16) Scheme chosen by scheme select register.
// (R17) Scheme changed only during initialization.
// (R18) Arbiter disabled around scheme writes.
// (R19) Queue index: function high, class low.
// (R20) Disabled queues are skipped.
// (R21) Buffers 1x160, 4x40 or 8x20 KB.
// (R22) Zero-sized buffer disables its class.
// (R23) Arbiter disable halts new grants.
module txq_path
    import txq_pkg::*;
#(
    parameter int NUM_QUEUES = TXQ_NUM_QUEUES,
    parameter int QUEUE_DEPTH = TXQ_QUEUE_DEPTH
) (
    // Clock and reset
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_rst,
    // APB slave
    input  wire logic                    i_psel,
    input  wire logic                    i_penable,
    input  wire logic                    i_pwrite,
    input  wire logic [11:0]             i_paddr,
    input  wire logic [31:0]             i_pwdata,
    output logic      [31:0]             o_prdata,
    output logic                         o_pready,
    output logic                         o_pslverr,
    // Descriptor fetch request and completion
    output logic                         o_fetch_req,
    output logic      [TXQ_QIDX_W-1:0]   o_fetch_queue,
    input  wire logic                    i_fetch_done,
    // Packet data read request and completion
    output logic                         o_data_req,
    output logic      [TXQ_QIDX_W-1:0]   o_data_queue,
    output logic      [TXQ_PB_IDX_W-1:0] o_data_pb,
    input  wire logic                    i_data_byte_valid,
    input  wire logic                    i_data_last,
    // Status write-back
    output logic                         o_wb_req,
    output logic      [TXQ_QIDX_W-1:0]   o_wb_queue,
    input  wire logic                    i_wb_done,
    // Packet toward MAC
    output logic                         o_mac_start,
    output logic      [TXQ_PB_IDX_W-1:0] o_mac_pb,
    input  wire logic                    i_mac_done
);

    localparam int CW = TXQ_CNT_W;
    localparam logic [CW-1:0] DEPTH_C = CW'(QUEUE_DEPTH);

    // Software settings, counters, state machines and registered outputs.
    logic                       arbdis_reg;
    logic                       wben_reg;
    logic [2:0]                 scheme_reg;
    logic [TXQ_QIDX_W-1:0]      qsel_reg;
    logic [NUM_QUEUES-1:0]      qen_reg;
    logic [CW-1:0]              pend_reg   [NUM_QUEUES];
    logic [CW-1:0]              ondie_reg  [NUM_QUEUES];
    logic [TXQ_PB_SIZE_W-1:0]   pbsize_reg [TXQ_NUM_PB];
    txq_state_type              st_reg;
    txq_out_state_type          ost_reg;
    logic [TXQ_QIDX_W-1:0]      cur_q_reg;
    logic [TXQ_QIDX_W-1:0]      rr_f_reg;
    logic [TXQ_QIDX_W-1:0]      rr_d_reg;
    logic [TXQ_PB_IDX_W-1:0]    rr_o_reg;
    logic [TXQ_NUM_PB-1:0]      pb_full_reg;
    logic [15:0]                pkt_bytes_reg;
    logic [31:0]                prdata_reg;
    logic                       pready_reg;
    logic                       pslverr_reg;
    logic                       fetch_req_reg;
    logic                       data_req_reg;
    logic                       wb_req_reg;
    logic                       mac_start_reg;
    logic [TXQ_PB_IDX_W-1:0]    mac_pb_reg;
    logic [TXQ_PB_IDX_W-1:0]    data_pb_reg;

    // APB decode.
    wire        apb_setup = i_psel && !i_penable;
    wire        apb_acc   = i_psel && i_penable && pready_reg;
    wire        apb_wr    = apb_acc && i_pwrite;
    wire        hit_ctrl  = i_paddr == TXQ_ADDR_CTRL;
    wire        hit_sch   = i_paddr == TXQ_ADDR_SCHEME;
    wire        hit_qsel  = i_paddr == TXQ_ADDR_QSEL;
    wire        hit_tail  = i_paddr == TXQ_ADDR_QTAIL;
    wire        hit_qstat = i_paddr == TXQ_ADDR_QSTAT;
    wire        hit_stat  = i_paddr == TXQ_ADDR_STATUS;
    wire        hit_pb    = i_paddr[11:5] == TXQ_ADDR_PBSIZE0[11:5] && i_paddr[1:0] == 2'h0;
    wire [2:0]  pb_sel    = i_paddr[4:2];
    wire        hit_any   = hit_ctrl | hit_sch | hit_qsel | hit_tail | hit_qstat
                          | hit_stat | hit_pb;
    wire        tail_wr   = apb_wr && hit_tail;
    wire [CW-1:0] tail_add = i_pwdata[CW-1:0];

    // Scheme fields.
    wire        vt_mode  = scheme_reg[2];
    wire [1:0]  tc_mode  = scheme_reg[1:0];

    // Queue to packet buffer map. [R13] [R19]
    function automatic logic [TXQ_PB_IDX_W-1:0] q2pb(input logic [TXQ_QIDX_W-1:0] q);
        logic [TXQ_PB_IDX_W-1:0] pb;
        pb = 3'h0;
        if (vt_mode) begin
            // Equal pools; low bits pick the class. [R14] [R15]
            if (tc_mode == TXQ_TCM_EIGHT)
                pb = q[2:0];
            else if (tc_mode == TXQ_TCM_FOUR)
                pb = {1'b0, q[1:0]};
        end else begin
            if (tc_mode == TXQ_TCM_EIGHT)
                pb = q[6] ? (q[5] ? {1'b1, q[4:3]} : {2'b01, q[4]}) : {2'b00, q[5]};
            else if (tc_mode == TXQ_TCM_FOUR)
                pb = {1'b0, q[6:5]};
        end
        return pb;
    endfunction : q2pb

    // Zero size disables a class. [R22] [R11]
    function automatic logic pb_on(input logic [TXQ_PB_IDX_W-1:0] pb);
        return pbsize_reg[pb] != '0;
    endfunction : pb_on

    // Round-robin queue search.
    wire [NUM_QUEUES-1:0] f_elig;
    wire [NUM_QUEUES-1:0] d_elig;
    genvar g;
    generate
        for (g = 0; g < NUM_QUEUES; g++) begin : g_elig
            // Disabled queues and classes are skipped. [R20]
            assign f_elig[g] = qen_reg[g] && pend_reg[g] != '0 && ondie_reg[g] != DEPTH_C
                             && pb_on(q2pb(TXQ_QIDX_W'(g))); // [R8]
            assign d_elig[g] = qen_reg[g] && ondie_reg[g] != '0
                             && pb_on(q2pb(TXQ_QIDX_W'(g)))
                             && !pb_full_reg[q2pb(TXQ_QIDX_W'(g))];
        end
    endgenerate

    function automatic logic [TXQ_QIDX_W:0] rr_pick(input logic [NUM_QUEUES-1:0] el,
                                                    input logic [TXQ_QIDX_W-1:0] st);
        logic [TXQ_QIDX_W:0]   res;
        logic [TXQ_QIDX_W-1:0] idx;
        res = '0;
        for (int k = NUM_QUEUES - 1; k >= 0; k--) begin
            idx = st + TXQ_QIDX_W'(k);
            if (el[idx])
                res = {1'b1, idx};
        end
        return res;
    endfunction : rr_pick

    wire [TXQ_QIDX_W:0] f_pick = rr_pick(f_elig, rr_f_reg); // [R9]
    wire [TXQ_QIDX_W:0] d_pick = rr_pick(d_elig, rr_d_reg);

    // Output arbiter.
    logic [TXQ_PB_IDX_W:0] o_pick;
    always_comb begin
        logic [TXQ_PB_IDX_W-1:0] p;
        p = '0;
        o_pick = '0;
        for (int k = TXQ_NUM_PB - 1; k >= 0; k--) begin
            p = rr_o_reg + TXQ_PB_IDX_W'(k);
            if (pb_full_reg[p] && pb_on(p))
                o_pick = {1'b1, p};
        end
    end

    wire [CW-1:0] cur_ondie = ondie_reg[cur_q_reg];

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            arbdis_reg  <= 1'b0;
            wben_reg    <= 1'b0;
            scheme_reg  <= TXQ_SCHEME_RESET;
            qsel_reg    <= '0;
            qen_reg     <= '0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            for (int i = 0; i < TXQ_NUM_PB; i++)
                pbsize_reg[i] <= (i == 0) ? TXQ_PB_KB_ONE : 8'h00;
        end else begin
            pready_reg  <= apb_setup;
            pslverr_reg <= apb_setup && !hit_any;
            if (apb_wr && hit_ctrl) begin
                arbdis_reg <= i_pwdata[TXQ_CTRL_ARBDIS_BIT];
                wben_reg   <= i_pwdata[TXQ_CTRL_WBEN_BIT];
            end
            // Scheme is set here only. [R16]
            if (apb_wr && hit_sch)
                scheme_reg <= i_pwdata[2:0];
            if (apb_wr && hit_qsel) begin
                qsel_reg          <= i_pwdata[TXQ_QIDX_W-1:0];
                qen_reg[i_pwdata[TXQ_QIDX_W-1:0]] <= i_pwdata[TXQ_QSEL_EN_BIT];
            end
            if (apb_wr && hit_pb)
                pbsize_reg[pb_sel] <= i_pwdata[TXQ_PB_SIZE_W-1:0];
            if (apb_setup && !i_pwrite) begin
                prdata_reg <= 32'h0000_0000;
                if (hit_ctrl)
                    prdata_reg <= {30'h0, wben_reg, arbdis_reg};
                if (hit_sch)
                    prdata_reg <= {29'h0, scheme_reg};
                if (hit_qsel)
                    prdata_reg <= {23'h0, qen_reg[qsel_reg], 1'b0, qsel_reg};
                if (hit_qstat)
                    prdata_reg <= {18'h0, pend_reg[qsel_reg], 2'h0, ondie_reg[qsel_reg]};
                if (hit_stat)
                    prdata_reg <= {pkt_bytes_reg, pb_full_reg, 4'h0, st_reg};
                if (hit_pb)
                    prdata_reg <= {24'h0, pbsize_reg[pb_sel]};
            end
        end
    end

    // Per-queue pending and on-die counts. [R7]
    generate
        for (g = 0; g < NUM_QUEUES; g++) begin : g_cnt
            wire my_tail  = tail_wr && qsel_reg == TXQ_QIDX_W'(g);
            wire my_fetch = st_reg == TXQ_ST_FETCH && i_fetch_done && cur_q_reg == TXQ_QIDX_W'(g);
            wire my_used  = st_reg == TXQ_ST_DATA && i_data_last && cur_q_reg == TXQ_QIDX_W'(g);
            always_ff @(posedge i_ref_clk or posedge i_rst) begin
                if (i_rst) begin
                    pend_reg[g]  <= '0;
                    ondie_reg[g] <= '0;
                end else begin
                    // Tail writes add descriptors. [R1]
                    pend_reg[g]  <= pend_reg[g] + (my_tail ? tail_add : '0)
                                  - (my_fetch ? CW'(1) : '0);
                    ondie_reg[g] <= ondie_reg[g] + (my_fetch ? CW'(1) : '0)
                                  - (my_used ? CW'(1) : '0);
                end
            end
        end
    endgenerate

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st_reg        <= TXQ_ST_IDLE;
            cur_q_reg     <= '0;
            rr_f_reg      <= '0;
            rr_d_reg      <= '0;
            fetch_req_reg <= 1'b0;
            data_req_reg  <= 1'b0;
            wb_req_reg    <= 1'b0;
            pkt_bytes_reg <= 16'h0000;
            data_pb_reg   <= '0;
        end else begin
            fetch_req_reg <= 1'b0;
            data_req_reg  <= 1'b0;
            wb_req_reg    <= 1'b0;
            unique case (st_reg)
                TXQ_ST_IDLE: begin
                    // No grants while disabled. [R23] [R18]
                    if (!arbdis_reg && d_pick[TXQ_QIDX_W]) begin
                        cur_q_reg     <= d_pick[TXQ_QIDX_W-1:0];
                        rr_d_reg      <= d_pick[TXQ_QIDX_W-1:0] + 1'b1;
                        data_pb_reg   <= q2pb(d_pick[TXQ_QIDX_W-1:0]);
                        data_req_reg  <= 1'b1;
                        pkt_bytes_reg <= 16'h0000;
                        st_reg        <= TXQ_ST_DATA;
                    end else if (!arbdis_reg && f_pick[TXQ_QIDX_W]) begin
                        cur_q_reg     <= f_pick[TXQ_QIDX_W-1:0];
                        rr_f_reg      <= f_pick[TXQ_QIDX_W-1:0] + 1'b1;
                        fetch_req_reg <= 1'b1;
                        st_reg        <= TXQ_ST_FETCH;
                    end
                end
                TXQ_ST_FETCH: begin
                    fetch_req_reg <= !i_fetch_done;
                    if (i_fetch_done)
                        st_reg <= TXQ_ST_IDLE;
                end
                TXQ_ST_DATA: begin
                    // Bytes arrive unaligned from any address; counted only. [R4]
                    data_req_reg <= !i_data_last;
                    if (i_data_byte_valid)
                        pkt_bytes_reg <= pkt_bytes_reg + 16'h0001;
                    if (i_data_last) begin
                        wb_req_reg <= wben_reg; // [R10]
                        st_reg     <= wben_reg ? TXQ_ST_WB : TXQ_ST_IDLE;
                    end
                end
                TXQ_ST_WB: begin
                    wb_req_reg <= !i_wb_done;
                    if (i_wb_done)
                        st_reg <= TXQ_ST_IDLE;
                end
                default: st_reg <= TXQ_ST_IDLE;
            endcase
        end
    end

    // Packet plane: a buffer becomes sendable only once its packet is whole.
    wire [TXQ_PB_IDX_W-1:0] cur_pb = data_pb_reg;
    wire pkt_whole = st_reg == TXQ_ST_DATA && i_data_last;
    wire pkt_sent  = ost_reg == TXQ_OS_SEND && i_mac_done;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pb_full_reg   <= '0;
            ost_reg       <= TXQ_OS_IDLE;
            rr_o_reg      <= '0;
            mac_start_reg <= 1'b0;
            mac_pb_reg    <= '0;
        end else begin
            mac_start_reg <= 1'b0;
            for (int i = 0; i < TXQ_NUM_PB; i++) begin
                // Arrival of a complete packet wins over a same-cycle drain.
                if (pkt_whole && cur_pb == TXQ_PB_IDX_W'(i))
                    pb_full_reg[i] <= 1'b1; // [R2]
                else if (pkt_sent && mac_pb_reg == TXQ_PB_IDX_W'(i))
                    pb_full_reg[i] <= 1'b0;
            end
            unique case (ost_reg)
                TXQ_OS_IDLE: begin
                    if (!arbdis_reg && o_pick[TXQ_PB_IDX_W]) begin
                        mac_pb_reg    <= o_pick[TXQ_PB_IDX_W-1:0]; // [R12]
                        rr_o_reg      <= o_pick[TXQ_PB_IDX_W-1:0] + 1'b1;
                        mac_start_reg <= 1'b1;
                        ost_reg       <= TXQ_OS_SEND;
                    end
                end
                TXQ_OS_SEND: begin
                    if (i_mac_done)
                        ost_reg <= TXQ_OS_IDLE;
                end
                default: ost_reg <= TXQ_OS_IDLE;
            endcase
        end
    end

    // Partition sizes are software-programmed; reset holds one 160 KB buffer. [R21]
    assign o_prdata      = prdata_reg;
    assign o_pready      = pready_reg;
    assign o_pslverr     = pslverr_reg;
    assign o_fetch_req   = fetch_req_reg;
    assign o_fetch_queue = cur_q_reg;
    assign o_data_req    = data_req_reg;
    assign o_data_queue  = cur_q_reg;
    assign o_data_pb     = cur_pb;
    assign o_wb_req      = wb_req_reg;
    assign o_wb_queue    = cur_q_reg;
    assign o_mac_start   = mac_start_reg;
    assign o_mac_pb      = mac_pb_reg;

endmodule : txq_path

// >>> verilog/txq_pkg.sv
// Package for the transmit descriptor queue path: register map, fields, modes.
// Assumes a 32-bit APB slave with one aligned word per register.
package txq_pkg;

    localparam int           TXQ_NUM_QUEUES  = 128;
    localparam int           TXQ_QIDX_W      = 7;
    localparam int           TXQ_QUEUE_DEPTH = 40;
    localparam int           TXQ_CNT_W       = 6;
    localparam int           TXQ_NUM_PB      = 8;
    localparam int           TXQ_PB_IDX_W    = 3;
    localparam int           TXQ_PB_SIZE_W   = 8;

    // Packet buffer sizes in KB for the three partitions.
    localparam logic [7:0]   TXQ_PB_KB_ONE   = 8'hA0;
    localparam logic [7:0]   TXQ_PB_KB_FOUR  = 8'h28;
    localparam logic [7:0]   TXQ_PB_KB_EIGHT = 8'h14;

    // Register byte offsets.
    localparam logic [11:0]  TXQ_ADDR_CTRL     = 12'h000;
    localparam logic [11:0]  TXQ_ADDR_SCHEME   = 12'h004;
    localparam logic [11:0]  TXQ_ADDR_QSEL     = 12'h008;
    localparam logic [11:0]  TXQ_ADDR_QTAIL    = 12'h00C;
    localparam logic [11:0]  TXQ_ADDR_QSTAT    = 12'h010;
    localparam logic [11:0]  TXQ_ADDR_STATUS   = 12'h014;
    localparam logic [11:0]  TXQ_ADDR_PBSIZE0  = 12'h020;

    // Field positions.
    localparam int           TXQ_CTRL_ARBDIS_BIT = 0;
    localparam int           TXQ_CTRL_WBEN_BIT   = 1;
    localparam int           TXQ_QSEL_EN_BIT     = 8;

    // Scheme select: {virtualization_mode, tc_mode[1:0]}.
    localparam logic [2:0]   TXQ_SCHEME_RESET    = 3'h0;
    localparam logic [1:0]   TXQ_TCM_ONE         = 2'h0;
    localparam logic [1:0]   TXQ_TCM_FOUR        = 2'h1;
    localparam logic [1:0]   TXQ_TCM_EIGHT       = 2'h2;

    typedef enum logic [3:0] {
        TXQ_ST_IDLE  = 4'h1,
        TXQ_ST_FETCH = 4'h2,
        TXQ_ST_DATA  = 4'h4,
        TXQ_ST_WB    = 4'h8
    } txq_state_type;

    typedef enum logic [1:0] {
        TXQ_OS_IDLE = 2'h1,
        TXQ_OS_SEND = 2'h2
    } txq_out_state_type;

endpackage : txq_pkg
